/* File: acr_pkg.sv */
// Constants shared by the attribute controller register bank
package acr_pkg;

  // ****************************************
  // Host I/O ports
  // ****************************************
  localparam logic [15:0] ACR_PORT_INDEX = 16'h03c0;
  localparam logic [15:0] ACR_PORT_DATA = 16'h03c1;
  localparam logic [15:0] ACR_PORT_STAT_MONO = 16'h03ba;
  localparam logic [15:0] ACR_PORT_STAT_COLOR = 16'h03da;

  // ****************************************
  // Data register indexes
  // ****************************************
  localparam logic [4:0] ACR_IDX_PAL_LAST = 5'h0f;
  localparam logic [4:0] ACR_IDX_MODE = 5'h10;
  localparam logic [4:0] ACR_IDX_BORDER = 5'h11;
  localparam logic [4:0] ACR_IDX_PLANE = 5'h12;
  localparam logic [4:0] ACR_IDX_PAN = 5'h13;
  localparam logic [4:0] ACR_IDX_CSEL = 5'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ACR_PAL_SRC_BIT = 5;
  localparam int ACR_DAC54_SRC_BIT = 7;
  localparam int ACR_BYTE_SAMPLE_BIT = 6;
  localparam int ACR_SPLIT_PAN_BIT = 5;
  localparam int ACR_BI_BIT = 3;
  localparam int ACR_NINTH_DOT_BIT = 2;

  // ****************************************
  // Writable bit masks, reserved bits read zero
  // ****************************************
  localparam logic [7:0] ACR_MASK_INDEX = 8'h3f;
  localparam logic [7:0] ACR_MASK_PAL = 8'h3f;
  localparam logic [7:0] ACR_MASK_MODE = 8'hec;
  localparam logic [7:0] ACR_MASK_BORDER = 8'hff;
  localparam logic [7:0] ACR_MASK_PLANE = 8'h0f;
  localparam logic [7:0] ACR_MASK_PAN = 8'h0f;
  localparam logic [7:0] ACR_MASK_CSEL = 8'h0f;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] ACR_RST_INDEX = 8'h00;
  localparam logic [7:0] ACR_RST_MODE = 8'h00;
  localparam logic [7:0] ACR_RST_BORDER = 8'h00;
  localparam logic [7:0] ACR_RST_PLANE = 8'h0f;
  localparam logic [7:0] ACR_RST_PAN = 8'h00;
  localparam logic [7:0] ACR_RST_CSEL = 8'h00;
  localparam logic [5:0] ACR_RST_PAL = 6'h00;

  // ****************************************
  // Pixel path constants
  // ****************************************
  localparam logic [7:0] ACR_LINE_CHAR_LO = 8'hc0;
  localparam logic [7:0] ACR_LINE_CHAR_HI = 8'hdf;
  localparam logic [3:0] ACR_PAN_TEXT_MAX = 4'h7;
  localparam logic [3:0] ACR_PAN_TEXT_ZERO = 4'h8;
  localparam logic [3:0] ACR_PAN_256_MAX = 4'h6;

endpackage

/* File: acr_palette_mem.sv */
// Sixteen-entry palette store with one write port and two registered read ports
`timescale 1ns/10ps

module acr_palette_mem
  import acr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [3:0] wrAddr,
  input wire logic [5:0] wrData,
  input wire logic [3:0] hostAddr,
  output logic [5:0] hostData,
  input wire logic [3:0] pixAddr,
  output logic [5:0] pixData
);

  typedef struct packed {
    logic [15:0][5:0] entry;
    logic [5:0] hostQ;
    logic [5:0] pixQ;
  } acr_pal_state_t;

  acr_pal_state_t state_reg;
  acr_pal_state_t state_next;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    // Reads see the old entry when written in the same cycle
    state_next.hostQ = state_reg.entry[hostAddr];
    state_next.pixQ = state_reg.entry[pixAddr];
    if (wrEn) begin
      state_next.entry[wrAddr] = wrData;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= '{entry: {16{ACR_RST_PAL}}, hostQ: ACR_RST_PAL, pixQ: ACR_RST_PAL};
    end else begin
      state_reg <= state_next;
    end
  end

  assign hostData = state_reg.hostQ;
  assign pixData = state_reg.pixQ;

endmodule

/* File: acr_attribute_ctrl.sv */
// Attribute controller: indexed register bank and pixel colour formation
`timescale 1ns/10ps

module acr_attribute_ctrl
  import acr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] ioAddr,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [7:0] ioWdata,
  output logic [7:0] ioRdata,
  output logic ioRdValid,
  input wire logic colorAddressing,
  input wire logic pixStrobe,
  input wire logic textMode,
  input wire logic borderActive,
  input wire logic [3:0] planeBits,
  input wire logic [7:0] attrByte,
  input wire logic [7:0] charCode,
  input wire logic dotOn,
  input wire logic ninthDot,
  input wire logic blinkPhase,
  input wire logic lineCompareHit,
  output logic [7:0] dacAddr,
  output logic dacValid,
  output logic [3:0] panShift
);

  typedef struct packed {
    logic flipData;
    logic [7:0] index;
    logic [7:0] mode;
    logic [7:0] border;
    logic [7:0] plane;
    logic [7:0] pan;
    logic [7:0] csel;
    logic rdPend;
    logic rdSelData;
    logic [7:0] rdData;
    logic rdValid;
    logic lastDot;
    logic byteHalf;
    logic [3:0] highNibble;
    logic s1Valid;
    logic s1Border;
    logic s1Byte;
    logic [7:0] s1ByteVal;
    logic [7:0] dacAddr;
    logic dacValid;
    logic [3:0] panShift;
  } acr_state_t;

  acr_state_t state_reg;
  acr_state_t state_next;

  logic [5:0] palHostQ;
  logic [5:0] palPixQ;
  logic palWr;
  logic [3:0] pixColor;
  logic [7:0] dataMux;
  logic bgIntensity;
  logic blinkHide;
  logic lineChar;
  logic dotVal;
  logic [3:0] textColor;
  logic byteMode;
  logic idxPort;
  logic dataPort;
  logic statPort;
  logic hostWrite;
  logic [3:0] panByte;
  logic [3:0] panText;
  logic [3:0] panOther;

  // ****************************************
  // Port decode
  // ****************************************
  // Full 16-bit decode, so aliases of the legacy ports stay silent
  assign idxPort = (ioAddr == ACR_PORT_INDEX);
  assign dataPort = (ioAddr == ACR_PORT_DATA);
  assign statPort = ioRd
    && (ioAddr == (colorAddressing ? ACR_PORT_STAT_COLOR : ACR_PORT_STAT_MONO));
  assign hostWrite = ioWr && idxPort;
  // Pairing only applies to graphics samples, text keeps one sample per pixel
  assign byteMode = state_reg.mode[ACR_BYTE_SAMPLE_BIT] && !textMode;

  // ****************************************
  // Palette store
  // ****************************************
  // Own host read port, so readback never disturbs the pixel lookup
  assign palWr = hostWrite && state_reg.flipData
    && (state_reg.index[4:0] <= ACR_IDX_PAL_LAST);

  acr_palette_mem uPal (
    .mclk(mclk),
    .rst(rst),
    .wrEn(palWr),
    .wrAddr(state_reg.index[3:0]),
    .wrData(ioWdata[5:0] & ACR_MASK_PAL[5:0]),
    .hostAddr(state_reg.index[3:0]),
    .hostData(palHostQ),
    .pixAddr(pixColor),
    .pixData(palPixQ)
  );

  // ****************************************
  // Pixel colour front end
  // ****************************************
  always_comb begin
    bgIntensity = state_reg.mode[ACR_BI_BIT] ? 1'b0 : attrByte[7];
    blinkHide = state_reg.mode[ACR_BI_BIT] && attrByte[7] && blinkPhase;
    lineChar = (charCode >= ACR_LINE_CHAR_LO) && (charCode <= ACR_LINE_CHAR_HI);
    // Ninth column keeps background unless a line character asks for the copy
    dotVal = ninthDot ? (state_reg.mode[ACR_NINTH_DOT_BIT] && lineChar && state_reg.lastDot)
      : dotOn;
    textColor = (dotVal && !blinkHide) ? attrByte[3:0] : {bgIntensity, attrByte[6:4]};
    pixColor = (textMode ? textColor : planeBits) & state_reg.plane[3:0];
  end

  // ****************************************
  // Pan table
  // ****************************************
  // Values off the table give no shift rather than wrapping around
  always_comb begin
    panByte = 4'h0;
    panText = 4'h0;
    panOther = 4'h0;
    // 256-colour mode takes even values only, one step per two source pixels
    if (!state_reg.pan[0] && (state_reg.pan[3:0] <= ACR_PAN_256_MAX)) begin
      panByte = {1'b0, state_reg.pan[3:1]};
    end
    // Text shifts one extra for the ninth column, so value 8 means none
    if (state_reg.pan[3:0] <= ACR_PAN_TEXT_MAX) begin
      panText = 4'(state_reg.pan[3:0] + 4'h1);
      panOther = state_reg.pan[3:0];
    end
  end

  // Readback of the selected data register
  always_comb begin
    dataMux = 8'h00;
    if (state_reg.index[4:0] <= ACR_IDX_PAL_LAST) begin
      dataMux = {2'b00, palHostQ};
    end else begin
      case (state_reg.index[4:0])
        ACR_IDX_MODE: dataMux = state_reg.mode;
        ACR_IDX_BORDER: dataMux = state_reg.border;
        ACR_IDX_PLANE: dataMux = state_reg.plane;
        ACR_IDX_PAN: dataMux = state_reg.pan;
        ACR_IDX_CSEL: dataMux = state_reg.csel;
        default: dataMux = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.rdValid = 1'b0;
    state_next.s1Valid = 1'b0;
    state_next.dacValid = 1'b0;

    // Host writes
    if (hostWrite) begin
      if (!state_reg.flipData) begin
        state_next.index = ioWdata & ACR_MASK_INDEX;
      end else begin
        case (state_reg.index[4:0])
          ACR_IDX_MODE: state_next.mode = ioWdata & ACR_MASK_MODE;
          ACR_IDX_BORDER: state_next.border = ioWdata & ACR_MASK_BORDER;
          ACR_IDX_PLANE: state_next.plane = ioWdata & ACR_MASK_PLANE;
          ACR_IDX_PAN: state_next.pan = ioWdata & ACR_MASK_PAN;
          ACR_IDX_CSEL: state_next.csel = ioWdata & ACR_MASK_CSEL;
          default: ;
        endcase
      end
      // Data writes to unimplemented indexes still advance the phase
      state_next.flipData = !state_reg.flipData;
    end
    // Status read wins, so software can always resynchronise the phase
    if (statPort) begin
      state_next.flipData = 1'b0;
    end

    // Host reads answer two cycles after the request
    state_next.rdPend = ioRd && (idxPort || dataPort);
    state_next.rdSelData = dataPort && state_reg.flipData;
    if (state_reg.rdPend) begin
      state_next.rdData = state_reg.rdSelData ? dataMux : state_reg.index;
      state_next.rdValid = 1'b1;
    end

    // Stage 0: palette lookup issued, side information held
    if (pixStrobe) begin
      if (!ninthDot) begin
        state_next.lastDot = dotOn;
      end
      state_next.s1Border = borderActive || !state_reg.index[ACR_PAL_SRC_BIT];
      state_next.s1Byte = byteMode;
      state_next.s1ByteVal = {state_reg.highNibble, pixColor};
      // A border sample never waits for a partner, or the overscan colour is lost
      if (byteMode && !borderActive) begin
        // Two plane samples make one pixel, so output rate halves
        state_next.byteHalf = !state_reg.byteHalf;
        state_next.highNibble = pixColor;
        state_next.s1Valid = state_reg.byteHalf;
      end else begin
        state_next.s1Valid = 1'b1;
      end
    end
    if (borderActive) begin
      state_next.byteHalf = 1'b0;
    end

    // Stage 1: DAC address formed from the border register, the paired plane samples or registered palette data
    if (state_reg.s1Valid) begin
      state_next.dacValid = 1'b1;
      if (state_reg.s1Border) begin
        state_next.dacAddr = state_reg.border;
      end else if (state_reg.s1Byte) begin
        state_next.dacAddr = state_reg.s1ByteVal;
      end else begin
        state_next.dacAddr = {state_reg.csel[3:2],
          state_reg.mode[ACR_DAC54_SRC_BIT] ? state_reg.csel[1:0] : palPixQ[5:4],
          palPixQ[3:0]};
      end
    end

    // Panning output
    if (state_reg.mode[ACR_SPLIT_PAN_BIT] && lineCompareHit) begin
      state_next.panShift = 4'h0;
    end else if (byteMode) begin
      state_next.panShift = panByte;
    end else if (textMode) begin
      state_next.panShift = panText;
    end else begin
      state_next.panShift = panOther;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= '{
        flipData: 1'b0,
        index: ACR_RST_INDEX,
        mode: ACR_RST_MODE,
        border: ACR_RST_BORDER,
        plane: ACR_RST_PLANE,
        pan: ACR_RST_PAN,
        csel: ACR_RST_CSEL,
        rdPend: 1'b0,
        rdSelData: 1'b0,
        rdData: 8'h00,
        rdValid: 1'b0,
        lastDot: 1'b0,
        byteHalf: 1'b0,
        highNibble: 4'h0,
        s1Valid: 1'b0,
        s1Border: 1'b0,
        s1Byte: 1'b0,
        s1ByteVal: 8'h00,
        dacAddr: 8'h00,
        dacValid: 1'b0,
        panShift: 4'h0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  assign ioRdata = state_reg.rdData;
  assign ioRdValid = state_reg.rdValid;
  assign dacAddr = state_reg.dacAddr;
  assign dacValid = state_reg.dacValid;
  assign panShift = state_reg.panShift;

endmodule

/* File: acr_attribute_ctrl_sva.sv */
// Port checker for the attribute controller
`timescale 1ns/10ps
module acr_attribute_ctrl_sva(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] ioAddr,
  input wire logic ioRd,
  input wire logic [7:0] ioRdata,
  input wire logic ioRdValid,
  input wire logic pixStrobe,
  input wire logic borderActive,
  input wire logic [7:0] dacAddr,
  input wire logic dacValid,
  input wire logic [3:0] panShift
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_rd_answer_two: assert property (ioRd && ioAddr[15:1] == 15'h01e0 |-> ##2 ioRdValid)
    else $error("read answer missing");
  a_rd_valid_cause: assert property (ioRdValid |-> $past(ioRd, 2))
    else $error("read answer without request");
  a_rd_data_hold: assert property (!ioRdValid |-> $stable(ioRdata))
    else $error("read data moved");
  a_stat_no_answer: assert property (ioRd && ioAddr[7:0] inside {8'hba, 8'hda} |-> ##2 !ioRdValid)
    else $error("status read answered");
  a_idx_reserved_zero: assert property (ioRd && ioAddr == 16'h03c0 |-> ##2 ioRdata[7:6] == 2'h0)
    else $error("index reserved bits set");
  a_border_answer: assert property (pixStrobe && borderActive |-> ##2 dacValid)
    else $error("border pixel lost");
  a_dac_cause: assert property (dacValid |-> $past(pixStrobe, 2))
    else $error("pixel without strobe");
  a_dac_hold: assert property (!dacValid |-> $stable(dacAddr))
    else $error("dac address moved");
  a_pan_limit: assert property (panShift <= 4'h8)
    else $error("pan out of range");
  c_read: cover property (ioRdValid);
  c_pixel: cover property (dacValid && !$past(borderActive, 2));
  c_border: cover property (pixStrobe && borderActive);
endmodule

/* File: acr_host_model.sv */
// Host processor model issuing legacy port cycles
`timescale 1ns/10ps
module acr_host_model
  import acr_pkg::*;
(
  input wire logic mclk,
  input wire logic colorAddressing,
  output logic [15:0] ioAddr,
  output logic ioWr,
  output logic ioRd,
  output logic [7:0] ioWdata
);
  initial begin
    ioAddr = 16'h0000;
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioWdata = 8'h00;
  end
  // Released lines go inverted so a stale value is never mistaken for data
  task cyc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(negedge mclk);
    ioAddr = a;
    ioWr = w;
    ioRd = !w;
    ioWdata = d;
    @(negedge mclk);
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioAddr = ~a;
    ioWdata = ~d;
  endtask
  task stat;
    cyc(colorAddressing ? ACR_PORT_STAT_COLOR : ACR_PORT_STAT_MONO, 1'b0, 8'h00);
  endtask
  // No retrace input here, so loads run only between pixel bursts
  task load(input logic [4:0] i, input logic [7:0] d);
    stat();
    cyc(ACR_PORT_INDEX, 1'b1, {3'h0, i});
    cyc(ACR_PORT_INDEX, 1'b1, d);
    stat();
    cyc(ACR_PORT_INDEX, 1'b1, 8'h20);
  endtask
endmodule

/* File: tb_attribute_controller_regs.sv */
// Self-checking bench for the attribute controller
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module tb_attribute_controller_regs
  import acr_pkg::*;
;
  logic mclk = 0, rst = 1, colorAddressing = 0, pixStrobe = 0;
  logic textMode = 0, borderActive = 0, lineCompareHit = 0, ioWr, ioRd, ioRdValid, dacValid;
  logic [3:0] planeBits = 0, panShift, c;
  logic [15:0] ioAddr;
  logic [7:0] ioWdata, ioRdata, dacAddr, e, f, rnd = 8'h13, rq[$], pq[$];
  logic [5:0] pal;
  logic [7:0] attrByte = 0, charCode = 0;
  logic dotOn = 0, ninthDot = 0, blinkPhase = 0;
  logic [4:0] tbl[6] = '{5'h03, ACR_IDX_MODE, ACR_IDX_BORDER, ACR_IDX_PLANE, ACR_IDX_PAN, ACR_IDX_CSEL};
  logic [7:0] msk[6] = '{ACR_MASK_PAL, ACR_MASK_MODE, ACR_MASK_BORDER, ACR_MASK_PLANE,
    ACR_MASK_PAN, ACR_MASK_CSEL};
  int fails = 0, cmp_count = 0;
  always #5 mclk = ~mclk;
  acr_attribute_ctrl uut(.mclk(mclk), .rst(rst), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
    .ioWdata(ioWdata), .ioRdata(ioRdata), .ioRdValid(ioRdValid),
    .colorAddressing(colorAddressing), .pixStrobe(pixStrobe), .textMode(textMode),
    .borderActive(borderActive), .planeBits(planeBits), .attrByte(attrByte), .charCode(charCode),
    .dotOn(dotOn), .ninthDot(ninthDot), .blinkPhase(blinkPhase), .lineCompareHit(lineCompareHit),
    .dacAddr(dacAddr), .dacValid(dacValid), .panShift(panShift));
  acr_host_model host(.mclk(mclk), .colorAddressing(colorAddressing), .ioAddr(ioAddr),
    .ioWr(ioWr), .ioRd(ioRd), .ioWdata(ioWdata));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task summarize;
    if (rq.size() + pq.size() != 0) fails++;
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task rchk(input logic [4:0] i, input logic [7:0] d);
    host.stat();
    host.cyc(ACR_PORT_INDEX, 1'b1, {3'h0, i});
    rq.push_back({3'h0, i});
    host.cyc(ACR_PORT_INDEX, 1'b0, 8'h00);
    rq.push_back(d);
    host.cyc(ACR_PORT_DATA, 1'b0, 8'h00);
  endtask
  task px(input logic [3:0] b, input logic brd, input logic v, input logic [7:0] d);
    if (v) pq.push_back(d);
    @(negedge mclk);
    pixStrobe = 1;
    planeBits = b;
    borderActive = brd;
    @(negedge mclk);
    pixStrobe = 0;
    borderActive = 0;
  endtask
  task tx(input logic [7:0] a, input logic [7:0] ch, input logic [2:0] dnb, input logic [7:0] d);
    attrByte = a;
    charCode = ch;
    {dotOn, ninthDot, blinkPhase} = dnb;
    px(4'h0, 1'b0, 1'b1, d);
  endtask
  // ****************************************
  // Result watcher
  // ****************************************
  always @(negedge mclk) begin
    if (ioRdValid) begin
      e = rq.size() ? rq.pop_front() : 8'hxx;
      `CHK(ioRdata, e)
    end
    if (dacValid) begin
      f = pq.size() ? pq.pop_front() : 8'hxx;
      `CHK(dacAddr, f)
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(negedge mclk);
    rst = 0;
    rq.push_back(8'h00);
    host.cyc(ACR_PORT_DATA, 1'b0, 8'h00);
    rchk(ACR_IDX_PLANE, ACR_RST_PLANE);
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      colorAddressing = rnd[0];
      host.load(tbl[k % 6], rnd);
      rchk(tbl[k % 6], rnd & msk[k % 6]);
    end
    host.load(5'h15, 8'hff);
    rchk(5'h15, 8'h00);
    rnd = lfsr(rnd);
    pal = rnd[5:0];
    host.load(5'h05, rnd);
    rnd = lfsr(rnd);
    c = rnd[3:0];
    host.load(ACR_IDX_CSEL, rnd);
    host.load(ACR_IDX_MODE, 8'h00);
    host.load(ACR_IDX_PLANE, 8'h0f);
    host.load(ACR_IDX_BORDER, 8'h5a);
    px(4'h5, 0, 1, {c[3:2], pal});
    host.load(ACR_IDX_MODE, 8'h80);
    px(4'h5, 0, 1, {c, pal[3:0]});
    px(4'h5, 1, 1, 8'h5a);
    host.load(ACR_IDX_PLANE, 8'h00);
    px(4'h5, 0, 1, {c, 4'h0});
    host.load(ACR_IDX_PLANE, 8'h0f);
    host.load(ACR_IDX_MODE, 8'h40);
    px(4'h5, 1, 1, 8'h5a);
    px(4'ha, 0, 0, 8'h00);
    px(4'h3, 0, 1, 8'ha3);
    host.load(ACR_IDX_MODE, 8'h00);
    host.load(ACR_IDX_PAN, 8'h03);
    `CHK(panShift, 4'h3)
    lineCompareHit = 1;
    textMode = 1;
    repeat (3) @(negedge mclk);
    `CHK(panShift, 4'h4)
    host.load(ACR_IDX_MODE, 8'h20);
    `CHK(panShift, 4'h0)
    lineCompareHit = 0;
    host.load(ACR_IDX_PAN, 8'h08);
    `CHK(panShift, 4'h0)
    host.load(ACR_IDX_MODE, 8'h04);
    tx(8'h05, 8'h41, 3'b100, {c[3:2], pal});
    tx(8'hd0, 8'h41, 3'b000, {c[3:2], 6'h00});
    tx(8'h05, 8'hc4, 3'b100, {c[3:2], pal});
    tx(8'h05, 8'hc4, 3'b110, {c[3:2], pal});
    tx(8'h05, 8'h41, 3'b110, {c[3:2], 6'h00});
    host.load(ACR_IDX_MODE, 8'h0c);
    tx(8'hd0, 8'h41, 3'b000, {c[3:2], pal});
    tx(8'h85, 8'h41, 3'b101, {c[3:2], 6'h00});
    tx(8'h85, 8'h41, 3'b100, {c[3:2], pal});
    repeat (5) @(negedge mclk);
    summarize();
  end
  // Generous bound: the sequence needs well under a third of it
  initial begin
    #200us;
    fails++;
    summarize();
  end
endmodule
bind acr_attribute_ctrl acr_attribute_ctrl_sva chk(.mclk(mclk), .rst(rst), .ioAddr(ioAddr),
  .ioRd(ioRd), .ioRdata(ioRdata), .ioRdValid(ioRdValid), .pixStrobe(pixStrobe),
  .borderActive(borderActive), .dacAddr(dacAddr), .dacValid(dacValid), .panShift(panShift));
